// ### buffer_ecc_device.sv
// Sector buffer manager and ECC device between host bus and disk controller
// Overview of operation
// - Host address zero reaches the sector buffer, not a task file register.
// - Interrupt rises at command end, clears on status read or command load.
// - Data request is high while host bytes are expected or available.
// - Master reset returns the device to idle and clears all flags.
// - Buffer counter advances one byte per falling edge of the step strobe.
// - While the controller owns the buffer, bus and strobes are released.
// - Buffer ready is active when the buffer is full or empty.
// - Address latch loads bus bits 7..0 as buffer address bits 14..7.
// - RAM select is asserted whenever the buffer is accessed.
// - Read strobe drives only while bus is free; targets controller or RAM.
// - Write strobe drives only while bus is free; targets controller or RAM.
// - A three bit controller address selects the register while selected.
// - Head and drive strobe loads three head and four drive lines.
// - ECC with 32 or 56 bit polynomial is computed on sector bytes.
// - Data ECC errors are retried by the device without the host.
// - A recovered error shows as a status bit, not as an error.
// - An unrecoverable error sets status error and its error register bit.
// - Sector sizes 128 to 1024 bytes, single or multiple sectors.
// - Buffer addressing covers 128 bytes up to 32K bytes.
// - Up to four drives with eight heads each can be selected.
// - Command starts on command write; later register loads ignored while busy.
// - Size field bits 6 and 5 choose the sector length.
`default_nettype none
module buffer_ecc_device
	import buffer_ecc_pkg::*;
#(
	parameter logic [14:0] BUF_BASE  = 15'h0000,
	parameter logic [1:0]  RETRY_MAX = 2'h2,
	parameter logic [55:0] POLY56    = 56'h00_0000_0000_0001,
	parameter logic [55:0] POLY32    = 56'h00_0000_0000_0001
) (
	input  wire logic       clock_in,                   // 100 MHz clock
	input  wire logic       rst_b_in,                   // Master reset, active low
	input  wire host_pins_s host_in,                    // Host strobes, address, data
	output var  logic [7:0] host_data_lines_out,        // Host read data
	output var  logic       host_data_lines_oe_out,     // Host data drive enable
	output var  logic       interrupt_request_out,      // Command complete
	output var  logic       host_data_request_out,      // Host byte wanted or ready
	input  wire logic [7:0] shared_addr_data_bus_in,    // Shared bus input
	output var  logic [7:0] shared_addr_data_bus_out,   // Shared bus output
	output var  logic       shared_addr_data_bus_oe_out,// Shared bus drive enable
	input  wire logic       buffer_owned_by_ctrl_b_in,  // Low while controller owns buffer
	output var  logic       buffer_counter_step_b_out,  // Falling edge steps counter
	output var  logic       buffer_ready_to_ctrl_out,   // Buffer full or empty
	output var  logic       addr_latch_out,             // Buffer address latch strobe
	output var  logic       ram_select_b_out,           // Buffer RAM select, low
	output var  logic       ctrl_select_b_out,          // Controller select, low
	output var  logic [2:0] ctrl_reg_addr_out,          // Controller register address
	output var  logic       ext_read_strobe_b_out,      // External read strobe, low
	output var  logic       ext_read_strobe_oe_out,     // Read strobe drive enable
	output var  logic       ext_write_strobe_b_out,     // External write strobe, low
	output var  logic       ext_write_strobe_oe_out,    // Write strobe drive enable
	output var  logic       head_drive_latch_strobe_out // Head and drive latch strobe
);
	host_pins_s  hs1_q, hs2_q, hs3_q;
	logic        bb1_q, bb2_q;
	logic [7:0]  ad1_q, ad2_q;
	state_e      st_q, bk_q;
	op_e         op_q;
	phase_e      ph_q;
	logic [2:0]  xp_q, cnt_q, xa_q, pa_q;
	logic        pend_q, pwr_q, xctl_q, xwr_q;
	logic [7:0]  pd_q, xd_q, xrd_q, cmd_q, sdh_q, scnt_q, hdo_q;
	logic [10:0] bcnt_q;
	logic [55:0] ecc_q;
	logic [1:0]  retry_q;
	logic        bad_q, seen_q, busy_q, irq_q, drq_q, corr_q, unc_q;
	logic        hoe_q, step_b_q, buffer_ready_to_ctrl_q, ale_q, rcs_b_q, xcs_b_q;
	logic        re_b_q, we_b_q, str_oe_q, hds_q, ad_oe_q;
	logic [7:0]  ad_o_q;

	// Synchronised host pins and shared bus
	wire         own     = ~bb2_q;
	// only strobes under chip select count
	wire         cs      = ~hs2_q.cs_b;
	wire         rd_ev   = cs & ~hs2_q.rd_b & hs3_q.rd_b;
	wire         wr_ev   = cs & ~hs2_q.wr_b & hs3_q.wr_b;
	wire         wide    = cmd_q[CMD_ECC56];
	wire         is_rd   = cmd_q[7:4] == CMD_READ;
	wire         is_wr   = cmd_q[7:4] == CMD_WRITE;
	// multiple sector when enabled and more remain
	wire         more    = cmd_q[CMD_MULTI] & (scnt_q > 8'h01);
	wire [10:0]  len     = sector_len(sdh_q[SDH_SZ_HI:SDH_SZ_LO]);
	wire [10:0]  nchk    = wide ? CHK56 : CHK32;
	wire [10:0]  bnext   = bcnt_q + 11'h001;
	wire [7:0]   ecc_top = wide ? ecc_q[55:48] : ecc_q[31:24];
	wire [55:0]  ecc_shl = wide ? {ecc_q[47:0], 8'h00} : {24'h0, ecc_q[23:0], 8'h00};
	// ECC update on the byte just moved
	wire [55:0]  ecc_nxt = ecc_step(ecc_q, op_q == OP_BWR ? xd_q : xrd_q, wide, POLY56, POLY32);
	wire         mis     = xrd_q != ecc_top;
	wire         bad_now = bad_q | (bcnt_q >= len & mis);
	// binary head number and one-hot drive select
	wire [3:0]   drv     = 4'(4'h1 << sdh_q[4:3]);
	wire [7:0]   hd_byte = {drv, 1'b0, sdh_q[2:0]};
	wire [7:0]   st_mrg  = xrd_q | {busy_q, 3'h0, drq_q, corr_q, busy_q, unc_q};
	wire [7:0]   er_mrg  = xrd_q | {1'b0, unc_q, 6'h00};
	wire         host_ok = (st_q == S_IDLE) | (st_q == S_XFER) | (st_q == S_HAND);
	wire         take    = host_ok & pend_q & ~own;
	// address zero is a buffer access
	wire         buf_acc = pa_q == ADDR_BUF;
	wire         acc     = (st_q == S_EXT) & ~own;
	wire         stb     = acc & (xp_q >= PH_STB_ON) & (xp_q <= PH_STB_OFF);

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hs1_q <= HOST_IDLE;
			hs2_q <= HOST_IDLE;
			hs3_q <= HOST_IDLE;
			bb1_q <= 1'b1;
			bb2_q <= 1'b1;
			ad1_q <= 8'h00;
			ad2_q <= 8'h00;
		end else begin
			hs1_q <= host_in;
			hs2_q <= hs1_q;
			hs3_q <= hs2_q;
			bb1_q <= buffer_owned_by_ctrl_b_in;
			bb2_q <= bb1_q;
			ad1_q <= shared_addr_data_bus_in;
			ad2_q <= ad1_q;
		end
	end

	// Host event capture; a new event wins over the service clear
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend_q <= 1'b0;
			pwr_q  <= 1'b0;
			pa_q   <= 3'h0;
			pd_q   <= 8'h00;
		end else if (rd_ev | wr_ev) begin
			pend_q <= 1'b1;
			pwr_q  <= wr_ev;
			pa_q   <= hs2_q.addr;
			pd_q   <= hs2_q.data;
		end else if (take) begin
			pend_q <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		// reset clears state and every flag
		if (!rst_b_in) begin
			st_q <= S_IDLE;
			bk_q <= S_IDLE;
			op_q <= OP_HRD;
			ph_q <= PH_HOST;
			xp_q <= 3'h0;
			cnt_q <= 3'h0;
			xa_q <= 3'h0;
			xctl_q <= 1'b0;
			xwr_q <= 1'b0;
			xd_q <= 8'h00;
			xrd_q <= 8'h00;
			cmd_q <= CMD_RST;
			sdh_q <= SDH_RST;
			scnt_q <= SCNT_RST;
			hdo_q <= 8'h00;
			bcnt_q <= 11'h000;
			ecc_q <= 56'h0;
			retry_q <= 2'h0;
			bad_q <= 1'b0;
			seen_q <= 1'b0;
			busy_q <= 1'b0;
			irq_q <= 1'b0;
			drq_q <= 1'b0;
			corr_q <= 1'b0;
			unc_q <= 1'b0;
		end else begin
			case (st_q)
				S_IDLE, S_XFER, S_HAND: begin
					if (take) begin
						xa_q <= pa_q;
						xd_q <= pd_q;
						xwr_q <= pwr_q;
						xctl_q <= 1'b1;
						xp_q <= 3'h0;
						bk_q <= st_q;
						if (buf_acc) begin
							// one byte per host buffer access
							if (drq_q & st_q == S_XFER) begin
								op_q <= pwr_q ? OP_BWR : OP_BRD;
								xctl_q <= 1'b0;
								st_q <= S_EXT;
							end
						end else if (pwr_q & busy_q) begin
							// loads during a command are dropped
						end else if (pwr_q & pa_q == ADDR_CMD) begin
							cmd_q <= pd_q;
							busy_q <= 1'b1;
							irq_q <= 1'b0;
							corr_q <= 1'b0;
							unc_q <= 1'b0;
							retry_q <= 2'h0;
							op_q <= OP_CMD;
							st_q <= S_EXT;
						end else if (pwr_q) begin
							if (pa_q == ADDR_SCNT)
								scnt_q <= pd_q;
							if (pa_q == ADDR_SDH)
								sdh_q <= pd_q;
							op_q <= OP_HWR;
							st_q <= S_EXT;
						end else begin
							if (pa_q == ADDR_CMD)
								irq_q <= 1'b0;
							op_q <= OP_HRD;
							st_q <= S_EXT;
						end
					end else if (st_q == S_HAND) begin
						if (own)
							seen_q <= 1'b1;
						if (seen_q & ~own) begin
							cnt_q <= 3'h0;
							if (is_rd) begin
								ph_q <= PH_CHECK;
								st_q <= S_ADDR;
							end else if (more) begin
								scnt_q <= scnt_q - 8'h01;
								ph_q <= PH_HOST;
								st_q <= S_ADDR;
							end else begin
								st_q <= S_DONE;
							end
						end
					end
				end
				S_START: begin
					cnt_q <= 3'h0;
					if (is_rd | is_wr) begin
						ph_q <= is_rd ? PH_FILL : PH_HOST;
						st_q <= S_ADDR;
					end else begin
						st_q <= S_DONE;
					end
				end
				S_ADDR: begin
					if (~own) begin
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == ALE_CYC - 3'h1) begin
							bcnt_q <= 11'h000;
							ecc_q <= 56'h0;
							bad_q <= 1'b0;
							seen_q <= 1'b0;
							if (ph_q == PH_HOST) begin
								// buffer now waits on the host
								drq_q <= 1'b1;
								st_q <= S_XFER;
							end else begin
								st_q <= ph_q == PH_FILL ? S_HAND : S_CHK;
							end
						end
					end
				end
				S_CHK, S_ECCW: begin
					if (~own) begin
						op_q <= st_q == S_CHK ? OP_CHK : OP_ECW;
						xwr_q <= st_q == S_ECCW;
						xd_q <= ecc_top;
						xctl_q <= 1'b0;
						xp_q <= 3'h0;
						st_q <= S_EXT;
					end
				end
				S_EXT: begin
					if (~own) begin
						xp_q <= xp_q + 3'h1;
						if (xp_q == PH_LAST) begin
							xrd_q <= ad2_q;
							st_q <= S_FIN;
						end
					end
				end
				S_FIN: begin
					st_q <= bk_q;
					case (op_q)
						OP_HRD: hdo_q <= xa_q == ADDR_CMD ? st_mrg : xa_q == ADDR_ERR ? er_mrg : xrd_q;
						OP_HWR: begin
							cnt_q <= 3'h0;
							if (xa_q == ADDR_SDH)
								st_q <= S_HDS;
						end
						OP_BRD, OP_BWR: begin
							hdo_q <= xrd_q;
							bcnt_q <= bnext;
							if (op_q == OP_BWR)
								ecc_q <= ecc_nxt;
							if (bnext == len) begin
								drq_q <= 1'b0;
								bcnt_q <= 11'h000;
								cnt_q <= 3'h0;
								if (op_q == OP_BWR) begin
									st_q <= S_ECCW;
								end else if (more) begin
									scnt_q <= scnt_q - 8'h01;
									ph_q <= PH_FILL;
									st_q <= S_ADDR;
								end else begin
									st_q <= S_DONE;
								end
							end
						end
						OP_CMD: st_q <= S_START;
						OP_CHK: begin
							bcnt_q <= bnext;
							bad_q <= bad_now;
							ecc_q <= bcnt_q < len ? ecc_nxt : ecc_shl;
							st_q <= S_CHK;
							if (bnext == len + nchk) begin
								cnt_q <= 3'h0;
								if (!bad_now) begin
									corr_q <= corr_q | (retry_q != 2'h0);
									ph_q <= PH_HOST;
									st_q <= S_ADDR;
								end else if (retry_q != RETRY_MAX) begin
									// reissue the read to the controller
									retry_q <= retry_q + 2'h1;
									op_q <= OP_CMD;
									xctl_q <= 1'b1;
									xwr_q <= 1'b1;
									xa_q <= ADDR_CMD;
									xd_q <= cmd_q;
									xp_q <= 3'h0;
									st_q <= S_EXT;
								end else begin
									unc_q <= 1'b1;
									st_q <= S_DONE;
								end
							end
						end
						OP_ECW: begin
							ecc_q <= ecc_shl;
							bcnt_q <= bnext;
							st_q <= bnext == nchk ? S_HAND : S_ECCW;
						end
						default: st_q <= S_IDLE;
					endcase
				end
				S_HDS: begin
					if (~own) begin
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == HDS_CYC - 3'h1)
							st_q <= bk_q;
					end
				end
				S_DONE: begin
					busy_q <= 1'b0;
					irq_q <= 1'b1;
					drq_q <= 1'b0;
					st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// Registered pin drivers
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hoe_q <= 1'b0;
			step_b_q <= 1'b1;
			buffer_ready_to_ctrl_q <= 1'b0;
			ale_q <= 1'b0;
			rcs_b_q <= 1'b1;
			xcs_b_q <= 1'b1;
			re_b_q <= 1'b1;
			we_b_q <= 1'b1;
			str_oe_q <= 1'b0;
			hds_q <= 1'b0;
			ad_oe_q <= 1'b0;
			ad_o_q <= 8'h00;
		end else begin
			hoe_q <= cs & ~hs2_q.rd_b;
			// one low cycle per buffer byte
			step_b_q <= ~(st_q == S_FIN & ~xctl_q);
			// full after host fill, empty before controller fill
			buffer_ready_to_ctrl_q <= st_q == S_HAND;
			// address latch while the device holds the bus
			ale_q <= ~own & st_q == S_ADDR;
			// RAM select on every buffer access
			rcs_b_q <= ~(acc & ~xctl_q);
			// controller select with its register address
			xcs_b_q <= ~(acc & xctl_q);
			// read strobe toward controller or RAM
			re_b_q <= ~(stb & ~xwr_q);
			// write strobe toward controller or RAM
			we_b_q <= ~(stb & xwr_q);
			// strobes and bus released to the controller
			str_oe_q <= ~own;
			hds_q <= ~own & st_q == S_HDS;
			// shared bus driven only while the device owns it
			ad_oe_q <= ~own & ((acc & xwr_q) | st_q == S_ADDR | st_q == S_HDS);
			// buffer address bits 14..7 on the bus
			ad_o_q <= st_q == S_ADDR ? BUF_BASE[14:7] : st_q == S_HDS ? hd_byte : xd_q;
		end
	end

	assign host_data_lines_out         = hdo_q;
	assign host_data_lines_oe_out      = hoe_q;
	assign interrupt_request_out       = irq_q;
	assign host_data_request_out       = drq_q;
	assign shared_addr_data_bus_out    = ad_o_q;
	assign shared_addr_data_bus_oe_out = ad_oe_q;
	assign buffer_counter_step_b_out   = step_b_q;
	assign buffer_ready_to_ctrl_out    = buffer_ready_to_ctrl_q;
	assign addr_latch_out              = ale_q;
	assign ram_select_b_out            = rcs_b_q;
	assign ctrl_select_b_out           = xcs_b_q;
	assign ctrl_reg_addr_out           = xa_q;
	assign ext_read_strobe_b_out       = re_b_q;
	assign ext_read_strobe_oe_out      = str_oe_q;
	assign ext_write_strobe_b_out      = we_b_q;
	assign ext_write_strobe_oe_out     = str_oe_q;
	assign head_drive_latch_strobe_out = hds_q;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	a_strobe_release: assert property (own |=> !ext_read_strobe_oe_out && !ext_write_strobe_oe_out)
		else $error("strobes driven while controller owns buffer");
	a_ale_owned: assert property (own |=> !addr_latch_out && ram_select_b_out && !shared_addr_data_bus_oe_out)
		else $error("address latch or RAM select while controller owns bus");
	a_ale_bus: assert property (addr_latch_out |-> shared_addr_data_bus_oe_out && shared_addr_data_bus_out == BUF_BASE[14:7])
		else $error("address latch without buffer address on bus");
	a_irq_done: assert property (st_q == S_DONE |=> interrupt_request_out && !busy_q)
		else $error("interrupt missing at command end");
	a_irq_clear: assert property (take && !pwr_q && pa_q == ADDR_CMD |=> !interrupt_request_out)
		else $error("status read did not clear interrupt");
	a_step_pulse: assert property ($fell(buffer_counter_step_b_out) |=> buffer_counter_step_b_out)
		else $error("counter step low longer than one cycle");
	a_sel_excl: assert property (!(!ram_select_b_out && !ctrl_select_b_out))
		else $error("RAM and controller selected together");
	a_ready_hand: assert property (buffer_ready_to_ctrl_out |-> $past(st_q) == S_HAND)
		else $error("buffer ready outside handover");
	a_drq_phase: assert property ($rose(host_data_request_out) |-> $past(st_q) == S_ADDR && st_q == S_XFER)
		else $error("data request raised outside host phase");
	a_busy_ignore: assert property (take && pwr_q && busy_q && !buf_acc |=> $stable(cmd_q) && $stable(sdh_q))
		else $error("register load accepted while busy");
	a_unc_final: assert property ($rose(unc_q) |-> $past(retry_q) == RETRY_MAX && st_q == S_DONE)
		else $error("uncorrectable flagged before retries ran out");
endmodule // buffer_ecc_device
`default_nettype wire

// ### buffer_ecc_pkg.sv
// Shared constants, types and helpers for the sector buffer and ECC manager
`default_nettype none
package buffer_ecc_pkg;
	// Host register addresses
	localparam logic [2:0] ADDR_BUF  = 3'h0;
	localparam logic [2:0] ADDR_ERR  = 3'h1;
	localparam logic [2:0] ADDR_SCNT = 3'h2;
	localparam logic [2:0] ADDR_SDH  = 3'h6;
	localparam logic [2:0] ADDR_CMD  = 3'h7;
	// Command opcode high nibbles and field positions
	localparam logic [3:0] CMD_READ  = 4'h2;
	localparam logic [3:0] CMD_WRITE = 4'h3;
	localparam int         CMD_ECC56 = 0;
	localparam int         CMD_MULTI = 2;
	localparam int         SDH_SZ_HI = 6;
	localparam int         SDH_SZ_LO = 5;
	// Status and error bit positions
	localparam int ST_BUSY = 7;
	localparam int ST_DRQ  = 3;
	localparam int ST_CORR = 2;
	localparam int ST_CIP  = 1;
	localparam int ST_ERR  = 0;
	localparam int ER_UNC  = 6;
	// Sector lengths and check byte counts
	localparam logic [10:0] SZ128  = 11'h080;
	localparam logic [10:0] SZ256  = 11'h100;
	localparam logic [10:0] SZ512  = 11'h200;
	localparam logic [10:0] SZ1024 = 11'h400;
	localparam logic [10:0] CHK32  = 11'h004;
	localparam logic [10:0] CHK56  = 11'h007;
	// Cycle counts of the external access sequences
	localparam logic [2:0] PH_STB_ON  = 3'h1;
	localparam logic [2:0] PH_STB_OFF = 3'h4;
	localparam logic [2:0] PH_LAST    = 3'h5;
	localparam logic [2:0] ALE_CYC    = 3'h2;
	localparam logic [2:0] HDS_CYC    = 3'h2;
	// Values after reset
	localparam logic [7:0] SDH_RST = 8'h00;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [7:0] SCNT_RST = 8'h01;

	typedef struct packed {
		logic       cs_b;
		logic       rd_b;
		logic       wr_b;
		logic [2:0] addr;
		logic [7:0] data;
	} host_pins_s;
	localparam host_pins_s HOST_IDLE = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};

	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_START = 4'h1, S_ADDR = 4'h3, S_XFER = 4'h2,
		S_EXT  = 4'h6, S_FIN   = 4'h7, S_ECCW = 4'h5, S_HAND = 4'h4,
		S_CHK  = 4'hC, S_HDS   = 4'hD, S_DONE = 4'hF
	} state_e;
	typedef enum logic [2:0] {
		OP_HRD, OP_HWR, OP_BRD, OP_BWR, OP_CMD, OP_CHK, OP_ECW
	} op_e;
	typedef enum logic [1:0] {PH_HOST, PH_FILL, PH_CHECK} phase_e;

	function automatic logic [10:0] sector_len(input logic [1:0] sz);
		case (sz)
			2'b11:   return SZ128;
			2'b00:   return SZ256;
			2'b01:   return SZ512;
			default: return SZ1024;
		endcase
	endfunction

	function automatic logic [55:0] ecc_step(input logic [55:0] e, input logic [7:0] b,
		input logic w, input logic [55:0] p56, input logic [55:0] p32);
		logic [55:0] r;
		logic        fb;
		r = e;
		for (int i = 7; i >= 0; i--) begin
			fb = (w ? r[55] : r[31]) ^ b[i];
			r = {r[54:0], 1'b0} ^ (fb ? (w ? p56 : p32) : 56'h0);
		end
		return w ? r : {24'h0, r[31:0]};
	endfunction
endpackage
`default_nettype wire

// ### disk_side_model.sv
// Disk controller, buffer RAM and latch model on the shared bus
`default_nettype none
module disk_side_model (
	input  wire logic       clock_in,  // Clock
	input  wire logic [7:0] bus_in,    // Resolved shared bus
	output var  logic [7:0] bus_out,   // Model bus data
	output var  logic       bus_oe_out,// Model drives bus
	output var  logic       own_b_out, // Controller owns buffer, low
	input  wire logic       step_b_in, // Counter step
	input  wire logic       ale_in,    // Address latch
	input  wire logic       rcs_b_in,  // RAM select
	input  wire logic       xcs_b_in,  // Controller select
	input  wire logic       re_b_in,   // Read strobe
	input  wire logic       we_b_in,   // Write strobe
	input  wire logic       hds_in,    // Head latch strobe
	input  wire logic       buffer_ready_to_ctrl_in    // Buffer ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  ram [0:32767];
	logic [14:0] cnt = 15'h0000;
	logic [7:0]  ctrl_wr = 8'h00;
	logic [7:0]  hd_latch = 8'h00;
	logic        step_d = 1'b1;
	// address load, then one count per falling step
	always @(posedge clock_in) begin
		step_d <= step_b_in;
		if (ale_in)
			cnt <= {bus_in, 7'h00};
		else if (step_d && !step_b_in)
			cnt <= cnt + 15'h0001;
	end
	always @(posedge we_b_in) begin
		if (!rcs_b_in) ram[cnt] <= bus_in;
		else if (!xcs_b_in) ctrl_wr <= bus_in;
	end
	// latch follows the bus while the strobe is high
	always @(posedge clock_in) if (hds_in) hd_latch <= bus_in;
	assign bus_oe_out = !re_b_in && (!rcs_b_in || !xcs_b_in);
	assign bus_out = !rcs_b_in ? ram[cnt] : 8'h00;
	// take buffer when ready, then release
	initial begin
		own_b_out = 1'b1;
		forever begin
			@(posedge buffer_ready_to_ctrl_in);
			repeat (5) @(posedge clock_in);
			#1 own_b_out = 1'b0;
			repeat (9) @(posedge clock_in);
			#1 own_b_out = 1'b1;
		end
	end
endmodule // disk_side_model
`default_nettype wire

// ### tb_disk_sector_buffer_ecc_manager.sv
// Self-checking bench for the sector buffer and ECC device
`default_nettype none
module tb_disk_sector_buffer_ecc_manager;
	timeunit 1ns;
	timeprecision 1ps;
	import buffer_ecc_pkg::*;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	host_pins_s host = HOST_IDLE;
	logic [7:0] rd_data, dev_bus, m_bus, bus, q, d;
	logic [7:0] last_q = 8'h00;
	logic dev_oe, m_oe, own_b, step_b, buffer_ready_to_ctrl, ale, rcs_b, xcs_b;
	logic re_b, re_oe, we_b, we_oe, head_drive_latch_strobe, irq, host_data_request, h_oe;
	logic [2:0] xa;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	always #5 clock_in = ~clock_in;
	assign bus = dev_oe ? dev_bus : (m_oe ? m_bus : ~last_q);
	always @(posedge clock_in) last_q <= bus;
	buffer_ecc_device DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .host_in(host),
		.host_data_lines_out(rd_data), .host_data_lines_oe_out(h_oe),
		.interrupt_request_out(irq), .host_data_request_out(host_data_request),
		.shared_addr_data_bus_in(bus), .shared_addr_data_bus_out(dev_bus),
		.shared_addr_data_bus_oe_out(dev_oe), .buffer_owned_by_ctrl_b_in(own_b),
		.buffer_counter_step_b_out(step_b), .buffer_ready_to_ctrl_out(buffer_ready_to_ctrl),
		.addr_latch_out(ale), .ram_select_b_out(rcs_b), .ctrl_select_b_out(xcs_b),
		.ctrl_reg_addr_out(xa), .ext_read_strobe_b_out(re_b),
		.ext_read_strobe_oe_out(re_oe), .ext_write_strobe_b_out(we_b),
		.ext_write_strobe_oe_out(we_oe), .head_drive_latch_strobe_out(head_drive_latch_strobe));
	disk_side_model m (.clock_in(clock_in), .bus_in(bus), .bus_out(m_bus),
		.bus_oe_out(m_oe), .own_b_out(own_b), .step_b_in(step_b), .ale_in(ale),
		.rcs_b_in(rcs_b), .xcs_b_in(xcs_b), .re_b_in(re_b), .we_b_in(we_b),
		.hds_in(head_drive_latch_strobe), .buffer_ready_to_ctrl_in(buffer_ready_to_ctrl));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic hacc(input logic w, input logic [2:0] a, input logic [7:0] v);
		@(negedge clock_in);
		// chip select stays low across the whole strobe
		host.cs_b = 1'b0;
		host.addr = a;
		host.data = v;
		@(negedge clock_in);
		host.rd_b = w;
		host.wr_b = !w;
		repeat (13) @(negedge clock_in);
		q = rd_data;
		if (!w) chk("host_oe", 8'h01, {7'h0, h_oe});
		host = HOST_IDLE;
		repeat (14) @(negedge clock_in);
		chk("host_oe_off", 8'h00, {7'h0, h_oe});
	endtask
	task automatic wait_for(ref logic s, input int n);
		for (int i = 0; i < n && s !== 1'b1; i++) @(negedge clock_in);
	endtask
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		logic [7:0] exp_q [$];
		logic [2:0] hd;
		void'($urandom(58));
		repeat (12) @(negedge clock_in);
		chk("irq", 8'h00, {7'h0, irq});
		chk("drq", 8'h00, {7'h0, host_data_request});
		chk("bus_oe", 8'h00, {7'h0, dev_oe});
		rst_b_in = 1'b1;
		repeat (2) @(negedge clock_in);
		for (int a = 1; a < 6; a++) begin
			d = 8'($urandom);
			hacc(1'b0 ^ 1'b1, 3'(a), d);
			chk("ctrl_addr", 8'(a), {5'h0, xa});
			chk("ctrl_data", d, m.ctrl_wr);
		end
		for (int dv = 0; dv < 4; dv++) begin
			hd = 3'($urandom);
			hacc(1'b1, ADDR_SDH, {3'b011, 2'(dv), hd});
			chk("head_latch", {4'h1 << dv, 1'b0, hd}, m.hd_latch);
		end
		hacc(1'b1, ADDR_CMD, 8'h10);
		wait_for(irq, 50);
		chk("irq_done", 8'h01, {7'h0, irq});
		hacc(1'b0, ADDR_CMD, 8'h00);
		chk("status", 8'h00, q);
		chk("irq_clr", 8'h00, {7'h0, irq});
		hacc(1'b1, ADDR_CMD, 8'h30);
		wait_for(host_data_request, 100);
		chk("drq_wr", 8'h01, {7'h0, host_data_request});
		hacc(1'b1, ADDR_SDH, 8'h00);
		chk("busy_sdh", {4'h8, 1'b0, hd}, m.hd_latch);
		for (int i = 0; i < 128; i++) begin
			d = 8'($urandom);
			exp_q.push_back(d);
			hacc(1'b1, ADDR_BUF, d);
		end
		chk("drq_end", 8'h00, {7'h0, host_data_request});
		wait_for(buffer_ready_to_ctrl, 3000);
		chk("buffer_ready_to_ctrl", 8'h01, {7'h0, buffer_ready_to_ctrl});
		while (own_b !== 1'b0 && buffer_ready_to_ctrl === 1'b1) @(negedge clock_in);
		repeat (4) @(negedge clock_in);
		chk("owned_oe", 8'h00, {5'h0, re_oe, we_oe, dev_oe});
		wait_for(irq, 500);
		chk("irq_wr", 8'h01, {7'h0, irq});
		for (int i = 0; i < 128; i++) begin
			chk("ram", exp_q[i], m.ram[i]);
		end
		hacc(1'b0, ADDR_ERR, 8'h00);
		chk("error_reg", 8'h00, q);
		hacc(1'b1, ADDR_CMD, 8'h20);
		wait_for(host_data_request, 3000);
		chk("drq_rd", 8'h01, {7'h0, host_data_request});
		for (int i = 0; i < 128; i++) begin
			hacc(1'b0, ADDR_BUF, 8'h00);
			chk("buf_rd", exp_q[i], q);
		end
		wait_for(irq, 500);
		chk("irq_rd", 8'h01, {7'h0, irq});
		hacc(1'b0, ADDR_CMD, 8'h00);
		chk("status_rd", 8'h00, q);
		complete_run();
	end
endmodule // tb_disk_sector_buffer_ecc_manager
`default_nettype wire
